/* File: rtl/asp_serial_port.sv */
`timescale 1ns/10ps
`default_nettype none
module asp_serial_port
  import asp_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire logic                 din,
  output var  logic                 dout_o,
  output var  logic                 dout_oe,
  input  wire logic                 comp_hi,
  output var  logic [ASP_RES_W-1:0] dac_code,
  output var  logic                 track_hold,
  output var  logic [ASP_CH_W-1:0]  channel_addr,
  output var  logic                 ref_off,
  output var  logic [ASP_PM_W-1:0]  power_mode_sel
);
  // ==================================================
  // pin synchronisers
  logic [2:0] cs_sync_q;
  logic [2:0] sclk_sync_q;
  logic [1:0] din_sync_q;
  logic [1:0] comp_sync_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cs_sync_q   <= 3'h7;
      sclk_sync_q <= 3'h0;
      din_sync_q  <= 2'h0;
      comp_sync_q <= 2'h0;
    end
    else
    begin
      cs_sync_q   <= {cs_sync_q[1:0], cs_n};
      sclk_sync_q <= {sclk_sync_q[1:0], sclk};
      din_sync_q  <= {din_sync_q[0], din};
      comp_sync_q <= {comp_sync_q[0], comp_hi};
    end
  end

  logic cs_low;
  logic cs_fall;
  logic rise;
  logic fall;
  logic din_s;

  assign cs_low  = !cs_sync_q[1];
  assign cs_fall = cs_sync_q[2] && !cs_sync_q[1];
  assign rise    = !sclk_sync_q[2] && sclk_sync_q[1];
  assign fall    = sclk_sync_q[2] && !sclk_sync_q[1];
  assign din_s   = din_sync_q[1];

  // ==================================================
  // conversion engine
  logic sar_step;
  logic sar_done;
  logic frame_start;

  asp_sar u_sar (
    .mclk    (mclk),
    .rst     (rst),
    .start   (frame_start),
    .step    (sar_step),
    .comp_hi (comp_sync_q[1]),
    .trial_q (dac_code),
    .busy_q  (track_hold),
    .done_q  (sar_done)
  );

  // frame bit p of the output word
  function automatic logic frame_bit(input logic [ASP_CNT_W-1:0] pos,
                                     input logic [ASP_RES_W-1:0] res);
    logic [ASP_CNT_W-1:0] idx;
    idx = ASP_LAST_POS - pos;
    if (pos < ASP_LEAD_ZEROS || pos > ASP_LAST_POS)
      frame_bit = 1'b0;
    else
      frame_bit = res[idx[ASP_IDX_W-1:0]];
  endfunction : frame_bit

  // ==================================================
  // frame sequencer
  asp_state_t            state_q;
  asp_state_t            state_d;
  logic [ASP_CNT_W-1:0]  cnt_q;
  logic [ASP_CNT_W-1:0]  cnt_d;
  logic [ASP_CTRL_W-2:0] shift_q;
  logic [ASP_CTRL_W-2:0] shift_d;
  logic [ASP_CTRL_W-1:0] ctrl_q;
  logic [ASP_CTRL_W-1:0] ctrl_d;
  logic [ASP_CH_W-1:0]   chan_q;
  logic [ASP_CH_W-1:0]   chan_d;
  logic                  dout_d;
  logic                  oe_d;
  logic                  ctrl_load;

  assign frame_start = cs_fall;
  // steps only on serial clock rises, so a stopped clock stalls the conversion
  assign sar_step  = rise && (state_q == ASP_SHIFT) && (cnt_q >= ASP_FIRST_STEP);
  assign ctrl_load = rise && (state_q == ASP_SHIFT) && (cnt_q == ASP_CTRL_LAST);

  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shift_d = shift_q;
    ctrl_d  = ctrl_q;
    chan_d  = chan_q;
    dout_d  = dout_o;
    oe_d    = cs_low;
    case (state_q)
      ASP_IDLE:
      begin
        if (cs_fall)
        begin
          state_d = ASP_SHIFT;
          cnt_d   = '0;
          dout_d  = 1'b0;
        end
      end
      ASP_SHIFT:
      begin
        if (rise)
        begin
          cnt_d   = cnt_q + 5'h01;
          shift_d = {shift_q[ASP_CTRL_W-3:0], din_s};
          if (cnt_q == ASP_LAST_POS)
            state_d = ASP_DONE;
        end
        if (fall)
          dout_d = frame_bit(cnt_q, dac_code);
      end
      ASP_DONE:
      begin
        if (fall)
          dout_d = 1'b0;
      end
      default:
        state_d = ASP_IDLE;
    endcase
    if (ctrl_load)
      ctrl_d = {shift_q, din_s};
    if (sar_done)
      chan_d = ctrl_q[ASP_CH_MSB:ASP_CH_LSB];
    // a select that rises mid-frame abandons the transfer
    if (!cs_low)
    begin
      state_d = ASP_IDLE;
      dout_d  = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ASP_IDLE;
      cnt_q   <= '0;
      shift_q <= '0;
      ctrl_q  <= ASP_CTRL_RST;
      chan_q  <= ASP_CH_RST;
      dout_o  <= 1'b0;
      dout_oe <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
      ctrl_q  <= ctrl_d;
      chan_q  <= chan_d;
      dout_o  <= dout_d;
      dout_oe <= oe_d;
    end
  end

  // ==================================================
  // analog controls, all registered
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      channel_addr   <= ASP_CH_RST;
      ref_off        <= 1'b0;
      power_mode_sel <= '0;
    end
    else
    begin
      channel_addr   <= chan_q;
      ref_off        <= ctrl_q[ASP_REF_BIT];
      power_mode_sel <= ctrl_q[ASP_PM_MSB:ASP_PM_LSB];
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  oe_release_a: assert property (cs_sync_q[1] |=> !dout_oe)
    else $error("data output driven while deselected");
  conv_start_a: assert property (cs_fall |=> ##1 track_hold && dac_code == 12'h800)
    else $error("conversion did not start on select fall");
  ctrl_load_a: assert property (ctrl_load |=> ctrl_q == $past({shift_q, din_s}))
    else $error("control word not loaded on eighth rise");
  ctrl_hold_a: assert property (!ctrl_load |=> $stable(ctrl_q))
    else $error("control register changed without a load");
  lead_zero_a: assert property (dout_oe && state_q == ASP_SHIFT && cnt_q <= 5'h03 |-> !dout_o)
    else $error("leading zero missing");
  out_edge_a: assert property (rise && state_q == ASP_SHIFT |=> $stable(dout_o))
    else $error("output changed on a rising edge");
  // a code change shows one cycle after the rise or start that caused it
  step_edge_a: assert property (!rise && !frame_start |=> $stable(dac_code))
    else $error("conversion moved without a serial edge");
  chan_update_a: assert property ($changed(chan_q) |-> $past(sar_done))
    else $error("channel changed before conversion end");
  ref_follow_a: assert property (ctrl_load |=> ##1 ref_off == ctrl_q[ASP_REF_BIT])
    else $error("reference control not following bit 2");
  din_sample_a: assert property (rise && state_q == ASP_SHIFT |=> shift_q[0] == $past(din_s))
    else $error("input bit not sampled on rise");
  chan_out_a: assert property ($changed(chan_q) |=> channel_addr == $past(chan_q))
    else $error("channel select not driven");
endmodule : asp_serial_port
`default_nettype wire

/* File: rtl/asp_pkg.sv */
`default_nettype none
package asp_pkg;
  // ==================================================
  // control word layout
  localparam int         ASP_CTRL_W     = 8;
  localparam int         ASP_CH_MSB     = 5;
  localparam int         ASP_CH_LSB     = 3;
  localparam int         ASP_CH_W       = 3;
  localparam int         ASP_REF_BIT    = 2;
  localparam int         ASP_PM_MSB     = 1;
  localparam int         ASP_PM_LSB     = 0;
  localparam int         ASP_PM_W       = 2;
  localparam logic [7:0] ASP_CTRL_RST   = 8'h00;
  localparam logic [2:0] ASP_CH_RST     = 3'h0;
  // ==================================================
  // frame shape
  localparam int         ASP_CNT_W      = 5;
  localparam logic [4:0] ASP_FRAME_BITS = 5'h10;
  localparam logic [4:0] ASP_CTRL_LAST  = 5'h07;
  localparam logic [4:0] ASP_LEAD_ZEROS = 5'h04;
  localparam logic [4:0] ASP_FIRST_STEP = 5'h01;
  localparam logic [4:0] ASP_LAST_POS   = 5'h0f;
  localparam int         ASP_RES_W      = 12;
  localparam int         ASP_IDX_W      = 4;
  localparam logic [3:0] ASP_IDX_TOP    = 4'hb;

  typedef enum logic [1:0] {
    ASP_IDLE,
    ASP_SHIFT,
    ASP_DONE
  } asp_state_t;
endpackage : asp_pkg
`default_nettype wire

/* File: rtl/asp_sar.sv */
`timescale 1ns/10ps
`default_nettype none
module asp_sar
  import asp_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   start,
  input  wire logic                   step,
  input  wire logic                   comp_hi,
  output var  logic [ASP_RES_W-1:0]   trial_q,
  output var  logic                   busy_q,
  output var  logic                   done_q
);
  // ==================================================
  // successive approximation, one decision per step
  logic [ASP_RES_W-1:0] trial_d;
  logic [ASP_IDX_W-1:0] idx_q;
  logic [ASP_IDX_W-1:0] idx_d;
  logic                 busy_d;
  logic                 done_d;

  always_comb
  begin
    trial_d = trial_q;
    idx_d   = idx_q;
    busy_d  = busy_q;
    done_d  = 1'b0;
    if (start)
    begin
      trial_d = {1'b1, {(ASP_RES_W-1){1'b0}}};
      idx_d   = ASP_IDX_TOP;
      busy_d  = 1'b1;
    end
    else if (step && busy_q)
    begin
      // comparator low means the trial code overshoots the held input
      if (!comp_hi)
        trial_d[idx_q] = 1'b0;
      if (idx_q == 4'h0)
      begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end
      else
      begin
        trial_d[idx_q - 4'h1] = 1'b1;
        idx_d = idx_q - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      trial_q <= '0;
      idx_q   <= '0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
    end
    else
    begin
      trial_q <= trial_d;
      idx_q   <= idx_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
    end
  end
endmodule : asp_sar
`default_nettype wire

/* File: tb/asp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module asp_host_model (
  input  wire logic mclk,
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic din,
  input  wire logic dout
);
  // phases of 6 mclk keep clear of the 4 mclk edge-detect minimum
  localparam int HALF = 6;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // ==============================
  // framed transfer, cut short when nrise is below 16
  task automatic xfer(input logic [15:0] w, input int nrise, output logic [15:0] r);
    logic [15:0] wm;
    wm = w & 16'hbfff;
    r  = 16'h0000;
    @(posedge mclk);
    cs_n <= 1'b0;
    din  <= wm[15];
    repeat (HALF) @(posedge mclk);
    for (int k = 0; k < nrise; k++)
    begin
      @(negedge mclk);
      r = {r[14:0], dout};
      @(posedge mclk);
      sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b0;
      din  <= (k < 15) ? wm[14-k] : 1'b0;
      repeat (HALF) @(posedge mclk);
    end
    cs_n <= 1'b1;
    din  <= 1'b0;
    repeat (HALF) @(posedge mclk);
  endtask : xfer
endmodule : asp_host_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
  import asp_pkg::*;
;
  logic                 mclk, rst, cs_n, sclk, din, dout_o, dout_oe, comp_hi;
  logic                 track_hold, ref_off, last_q, dout_line;
  logic [ASP_RES_W-1:0] dac_code;
  logic [ASP_CH_W-1:0]  channel_addr;
  logic [ASP_PM_W-1:0]  power_mode_sel;
  logic [11:0]          vin [8] = '{12'h5a5, 12'hfff, 12'h000, 12'h800,
                                    12'h7ff, 12'h123, 12'habc, 12'h001};
  int                   error_cnt = 0;
  int                   n_checks = 0;

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // ==============================
  // analog side and shared data line
  always @(posedge mclk) comp_hi <= (vin[channel_addr] >= dac_code);
  always @(posedge mclk) if (dout_oe === 1'b1) last_q <= dout_o;
  // released line shows the inverse so a stale bit cannot pass
  assign dout_line = (dout_oe === 1'b1) ? dout_o : ~last_q;

  asp_serial_port dut_u (
    .mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout_o(dout_o), .dout_oe(dout_oe), .comp_hi(comp_hi), .dac_code(dac_code),
    .track_hold(track_hold), .channel_addr(channel_addr), .ref_off(ref_off),
    .power_mode_sel(power_mode_sel)
  );
  asp_host_model host_u (
    .mclk(mclk), .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout_line)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
  // ==============================
  // main sequence
  initial
  begin
    logic [15:0] r;
    logic [7:0]  w;
    logic [2:0]  ch;
    rst     = 1'b1;
    ch      = 3'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check("chan_rst", {13'h0, channel_addr}, 16'h0000);
    check("ctrl_rst", {13'h0, ref_off, power_mode_sel}, 16'h0000);
    check("oe_idle", {15'h0, dout_oe}, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      // ignored bit toggles, channel walks down, ref and mode take every code
      w = {i[0], 1'b0, 3'(7 - i), i[2:0]};
      host_u.xfer({w, 8'hff}, 16, r);
      check("frame", r, {4'h0, vin[ch]});
      check("code", {4'h0, dac_code}, {4'h0, vin[ch]});
      check("hold_end", {15'h0, track_hold}, 16'h0000);
      check("ctrl", {10'h0, channel_addr, ref_off, power_mode_sel}, {10'h0, w[5:0]});
      check("oe_off", {15'h0, dout_oe}, 16'h0000);
      ch = w[5:3];
    end
    host_u.xfer({8'h28, 8'h00}, 4, r);
    check("abort_ctrl", {13'h0, ref_off, power_mode_sel}, {13'h0, w[2:0]});
    // serial clock stopped mid-conversion, so the conversion stays busy
    check("hold_stall", {15'h0, track_hold}, 16'h0001);
    host_u.xfer({8'h0f, 8'h00}, 16, r);
    check("after_abort", r, {4'h0, vin[ch]});
    check("chan_new", {13'h0, channel_addr}, 16'h0001);
    check("ctrl_set", {13'h0, ref_off, power_mode_sel}, 16'h0007);
    // second reset with a written word in place
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check("ctrl_clr", {10'h0, channel_addr, ref_off, power_mode_sel}, 16'h0000);
    check("oe_clr", {14'h0, dout_oe, track_hold}, 16'h0000);
    conclude();
  end
endmodule : tb
`default_nettype wire
